// *** hw/spc_port.sv ***
// Summary of operation
// - twelve 16-bit registers, 0xC0C8 to 0xC0DE
// - bit 15 shares data wire, half duplex
// - bit 14 selects clock phase, controller only
// - bit 13 selects clock polarity
// - bits 12:9 scale the controller clock rate
// - scale codes map 12 MHz down to 250 kHz
// - bit 7 reads controller machine active
// - role bit writable only while machine idle
// - bit 5 enables select output, else released
// - zero timing field means manual select
// - nonzero timing gives half-bit select delays
// - manual force bit drives select low/high
// - full duplex refused while data wire shared
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module spc_port
  import spc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [1:0]  wb_sel_i,
  input  wire logic [15:0] wb_dat_i,
  output logic [15:0]      wb_dat_o,
  output logic             wb_ack_o,
  // spi pins
  output logic             sck_o,
  output logic             sel_n_o,
  output logic             sel_n_oe,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  input  wire logic        sdio_i
);
  // ----------------------------------------------------------------
  // registers and signals
  // ----------------------------------------------------------------
  logic [15:0]    cfg, next_cfg;
  logic [15:0]    ctl, next_ctl;
  logic [15:0]    ien, next_ien;
  logic [15:0]    scratch [6];
  logic [15:0]    next_scratch [6];
  logic           ack, next_ack;
  logic [15:0]    rdat, next_rdat;
  logic           wr_hit, rd_hit;
  logic [15:0]    wmask;
  spc_state_t     st, next_st;
  logic [SPC_HB_W-1:0] hcnt, next_hcnt;
  logic [4:0]     dcnt, next_dcnt;
  logic [3:0]     bcnt, next_bcnt;
  logic [7:0]     shreg, next_shreg;
  logic           sck_lvl, next_sck_lvl;
  logic           sel_auto, next_sel_auto;
  logic           data_o, next_data_o;
  logic [2:0]     miso_s, sdio_s;
  logic           miso_q, next_miso_q;
  logic           active;
  logic           tick;
  logic           auto_mode;
  logic           tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0]     tx_out_data;
  logic           tx_full, tx_empty;
  logic           finit;
  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;
  assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign active = (st != SPC_IDLE);
  assign auto_mode = (cfg[SPC_CFG_DLY_HI:0] != 5'h00);
  assign finit = wr_hit && (wb_adr_i == SPC_ADR_CTL) && wb_dat_i[SPC_CTL_FINIT] && wb_sel_i[1];
  // register writes, one-cycle ack
  always_comb begin
    logic [15:0] w;
    w            = '0;
    next_cfg     = cfg;
    next_ctl     = ctl;
    next_ien     = ien;
    next_scratch = scratch;
    next_ack     = wb_cyc_i && wb_stb_i && !ack;
    next_rdat    = rdat;
    if (wr_hit) begin
      case (wb_adr_i)
        SPC_ADR_CFG: begin
          w = (cfg & ~wmask) | (wb_dat_i & wmask);
          next_cfg = w & SPC_CFG_WR_MASK;
          if (active) next_cfg[SPC_CFG_CTRL] = cfg[SPC_CFG_CTRL];
        end
        SPC_ADR_CTL: begin
          w = (ctl & ~wmask) | (wb_dat_i & wmask);
          next_ctl = w & SPC_CTL_RW_MASK;
        end
        SPC_ADR_IEN:  next_ien = ((ien & ~wmask) | (wb_dat_i & wmask)) & SPC_IEN_MASK;
        SPC_ADR_CRCC: next_scratch[0] = (scratch[0] & ~wmask) | (wb_dat_i & wmask);
        SPC_ADR_CRCV: next_scratch[1] = (scratch[1] & ~wmask) | (wb_dat_i & wmask);
        SPC_ADR_TXA:  next_scratch[2] = (scratch[2] & ~wmask) | (wb_dat_i & wmask);
        SPC_ADR_TXC:  next_scratch[3] = (scratch[3] & ~wmask) | (wb_dat_i & wmask);
        SPC_ADR_RXA:  next_scratch[4] = (scratch[4] & ~wmask) | (wb_dat_i & wmask);
        SPC_ADR_RXC:  next_scratch[5] = (scratch[5] & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
    // full duplex cannot stand while the data wire is shared
    if (next_cfg[SPC_CFG_SHARED]) next_ctl[SPC_CTL_FDUP] = 1'b0;
    if (rd_hit) begin
      case (wb_adr_i)
        SPC_ADR_CFG: begin
          next_rdat = cfg;
          next_rdat[SPC_CFG_ACTIVE] = active;
          next_rdat[SPC_CFG_RSVD]   = 1'b0;
        end
        SPC_ADR_CTL: begin
          next_rdat = ctl;
          next_rdat[SPC_CTL_TXRDY] = !tx_full;
          next_rdat[SPC_CTL_RXRDY] = 1'b0;
          next_rdat[SPC_CTL_TXEMP] = tx_empty;
          next_rdat[SPC_CTL_RXFUL] = 1'b0;
        end
        SPC_ADR_IEN:  next_rdat = ien;
        SPC_ADR_STAT: next_rdat = 16'h0000;
        SPC_ADR_CRCC: next_rdat = scratch[0];
        SPC_ADR_CRCV: next_rdat = scratch[1];
        SPC_ADR_DATA: next_rdat = {8'h00, shreg};
        SPC_ADR_TXA:  next_rdat = scratch[2];
        SPC_ADR_TXC:  next_rdat = scratch[3];
        SPC_ADR_RXA:  next_rdat = scratch[4];
        SPC_ADR_RXC:  next_rdat = scratch[5];
        default:      next_rdat = 16'h0000;  // write-only and unmapped read zero
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg  <= SPC_CFG_RESET;
      ctl  <= SPC_CTL_RESET;
      ien  <= '0;
      ack  <= 1'b0;
      rdat <= '0;
      for (int i = 0; i < 6; i++) scratch[i] <= '0;
    end else begin
      cfg     <= next_cfg;
      ctl     <= next_ctl;
      ien     <= next_ien;
      ack     <= next_ack;
      rdat    <= next_rdat;
      scratch <= next_scratch;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  // ----------------------------------------------------------------
  // transmit fifo fed by data register writes
  // ----------------------------------------------------------------
  assign tx_in_valid = wr_hit && (wb_adr_i == SPC_ADR_DATA) && wb_sel_i[0];
  spc_fifo #(.W(SPC_FIFO_W), .D(SPC_FIFO_D)) u_txf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (finit),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (wb_dat_i[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (tx_out_data),
    .full      (tx_full),
    .empty     (tx_empty)
  );
  // ----------------------------------------------------------------
  // input synchronisers, three stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      miso_s <= '0;
      sdio_s <= '0;
      miso_q <= 1'b0;
    end else begin
      miso_s <= {miso_s[1:0], miso_i};
      sdio_s <= {sdio_s[1:0], sdio_i};
      miso_q <= next_miso_q;
    end
  end
  // accept a change once stages two and three agree; shared wire reads sdio
  always_comb begin
    next_miso_q = miso_q;
    if (cfg[SPC_CFG_SHARED]) begin
      if (sdio_s[1] == sdio_s[2]) next_miso_q = sdio_s[2];
    end else begin
      if (miso_s[1] == miso_s[2]) next_miso_q = miso_s[2];
    end
  end
  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  assign tick = (hcnt == '0);
  assign tx_out_ready = (st == SPC_IDLE) && cfg[SPC_CFG_CTRL] && tx_out_valid;
  always_comb begin
    next_st       = st;
    next_hcnt     = tick ? spc_half_cycles(cfg[SPC_CFG_SCL_HI:SPC_CFG_SCL_LO]) - 1'b1
                         : hcnt - 1'b1;
    next_dcnt     = dcnt;
    next_bcnt     = bcnt;
    next_shreg    = shreg;
    next_sck_lvl  = sck_lvl;
    next_sel_auto = sel_auto;
    next_data_o   = data_o;
    case (st)
      SPC_IDLE: begin
        next_sck_lvl = 1'b0;
        if (tx_out_ready) begin
          next_shreg    = tx_out_data;
          next_bcnt     = 4'h0;
          next_dcnt     = cfg[SPC_CFG_DLY_HI:0];
          next_sel_auto = 1'b0;
          next_hcnt     = spc_half_cycles(cfg[SPC_CFG_SCL_HI:SPC_CFG_SCL_LO]) - 1'b1;
          // advanced phase puts first bit out before the first edge
          next_data_o   = tx_out_data[7];
          // the shift state spends one half bit before its first edge, so lead runs one short
          next_st       = (auto_mode && (cfg[SPC_CFG_DLY_HI:0] != 5'h01)) ? SPC_LEAD : SPC_SHIFT;
        end
      end
      SPC_LEAD: if (tick) begin
        next_dcnt = dcnt - 1'b1;
        if (dcnt == 5'h02) next_st = SPC_SHIFT;
      end
      SPC_SHIFT: if (tick) begin
        next_sck_lvl = !sck_lvl;
        if (!sck_lvl) begin
          // leading edge: advanced phase samples, delayed phase drives
          // take the filtered bit in the cycle it is accepted: at the fastest scale
          // the synchroniser delay equals one half bit
          if (cfg[SPC_CFG_PHASE]) next_shreg = {shreg[6:0], next_miso_q};
          else next_data_o = shreg[7];
        end else begin
          if (!cfg[SPC_CFG_PHASE]) next_shreg = {shreg[6:0], next_miso_q};
          else next_data_o = shreg[7];
          next_bcnt = bcnt + 1'b1;
          if (bcnt == 4'h7) begin
            next_dcnt = cfg[SPC_CFG_DLY_HI:0];
            next_st   = auto_mode ? SPC_TRAIL : SPC_IDLE;
          end
        end
      end
      SPC_TRAIL: if (tick) begin
        next_dcnt = dcnt - 1'b1;
        if (dcnt == 5'h01) begin
          next_sel_auto = 1'b1;
          next_dcnt     = cfg[SPC_CFG_DLY_HI:0];
          next_st       = SPC_GAP;
        end
      end
      SPC_GAP: if (tick) begin
        next_dcnt = dcnt - 1'b1;
        if (dcnt == 5'h01) next_st = SPC_IDLE;
      end
      default: next_st = SPC_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st       <= SPC_IDLE;
      hcnt     <= '0;
      dcnt     <= '0;
      bcnt     <= '0;
      shreg    <= '0;
      sck_lvl  <= 1'b0;
      sel_auto <= 1'b1;
      data_o   <= 1'b0;
    end else begin
      st       <= next_st;
      hcnt     <= next_hcnt;
      dcnt     <= next_dcnt;
      bcnt     <= next_bcnt;
      shreg    <= next_shreg;
      sck_lvl  <= next_sck_lvl;
      sel_auto <= next_sel_auto;
      data_o   <= next_data_o;
    end
  end
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // negative polarity idles high, positive idles low
  assign sck_o    = sck_lvl ^ !cfg[SPC_CFG_POL];
  // manual select follows force bit, auto select follows sequencer
  assign sel_n_o  = auto_mode ? sel_auto : !ctl[SPC_CTL_FORCE];
  assign sel_n_oe = cfg[SPC_CFG_CTRL] && cfg[SPC_CFG_SELEN];
  assign mosi_o   = data_o;
  // shared wire is released only while the machine is idle
  assign mosi_oe  = cfg[SPC_CFG_CTRL] && (!cfg[SPC_CFG_SHARED] || active);
endmodule : spc_port
`default_nettype wire

// *** inc/spc_pkg.sv ***
package spc_pkg;
  // ----------------------------------------------------------------
  // register map (16-bit registers, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] SPC_ADR_CFG    = 16'hc0c8;
  localparam logic [15:0] SPC_ADR_CTL    = 16'hc0ca;
  localparam logic [15:0] SPC_ADR_IEN    = 16'hc0cc;
  localparam logic [15:0] SPC_ADR_STAT   = 16'hc0ce;
  localparam logic [15:0] SPC_ADR_ICLR   = 16'hc0d0;
  localparam logic [15:0] SPC_ADR_CRCC   = 16'hc0d2;
  localparam logic [15:0] SPC_ADR_CRCV   = 16'hc0d4;
  localparam logic [15:0] SPC_ADR_DATA   = 16'hc0d6;
  localparam logic [15:0] SPC_ADR_TXA    = 16'hc0d8;
  localparam logic [15:0] SPC_ADR_TXC    = 16'hc0da;
  localparam logic [15:0] SPC_ADR_RXA    = 16'hc0dc;
  localparam logic [15:0] SPC_ADR_RXC    = 16'hc0de;
  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int SPC_CFG_SHARED = 15;
  localparam int SPC_CFG_PHASE  = 14;
  localparam int SPC_CFG_POL    = 13;
  localparam int SPC_CFG_SCL_HI = 12;
  localparam int SPC_CFG_SCL_LO = 9;
  localparam int SPC_CFG_RSVD   = 8;
  localparam int SPC_CFG_ACTIVE = 7;
  localparam int SPC_CFG_CTRL   = 6;
  localparam int SPC_CFG_SELEN  = 5;
  localparam int SPC_CFG_DLY_HI = 4;
  localparam logic [15:0] SPC_CFG_RESET    = 16'h801f;
  localparam logic [15:0] SPC_CFG_WR_MASK  = 16'hfe7f;
  // control fields
  localparam int SPC_CTL_STROBE = 15;
  localparam int SPC_CTL_FINIT  = 14;
  localparam int SPC_CTL_FDUP   = 12;
  localparam int SPC_CTL_FORCE  = 11;
  localparam int SPC_CTL_TXRDY  = 9;
  localparam int SPC_CTL_RXRDY  = 8;
  localparam int SPC_CTL_TXEMP  = 7;
  localparam int SPC_CTL_RXFUL  = 6;
  localparam logic [15:0] SPC_CTL_RESET   = 16'h0000;
  localparam logic [15:0] SPC_CTL_RW_MASK = 16'h3c3f;
  localparam logic [15:0] SPC_IEN_MASK    = 16'h0007;
  // ----------------------------------------------------------------
  // timing: core clock 100 MHz; sck half periods scaled from 48 MHz
  // ----------------------------------------------------------------
  localparam int SPC_CLK_MHZ   = 100;
  localparam int SPC_BASE_MHZ  = 48;
  localparam int SPC_FIFO_W    = 8;
  localparam int SPC_FIFO_D    = 16;
  localparam int SPC_HB_W      = 8;
  // half-bit period in base-clock cycles per scale code
  function automatic int spc_div48(input logic [3:0] code);
    case (code)
      4'h0: spc_div48 = 2;
      4'h1: spc_div48 = 3;
      4'h2: spc_div48 = 4;
      4'h3: spc_div48 = 6;
      4'h4: spc_div48 = 8;
      4'h5: spc_div48 = 12;
      4'h6: spc_div48 = 16;
      4'h7: spc_div48 = 24;
      4'h8: spc_div48 = 32;
      4'h9: spc_div48 = 48;
      4'ha, 4'hc, 4'he: spc_div48 = 64;
      default: spc_div48 = 96;
    endcase
  endfunction : spc_div48
  // half-bit in core cycles, rounded down, never below one
  function automatic logic [SPC_HB_W-1:0] spc_half_cycles(input logic [3:0] code);
    int n;
    n = (spc_div48(code) * SPC_CLK_MHZ) / SPC_BASE_MHZ;
    if (n < 1) n = 1;
    spc_half_cycles = SPC_HB_W'(n);
  endfunction : spc_half_cycles
  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SPC_IDLE  = 5'b00001,
    SPC_LEAD  = 5'b00010,
    SPC_SHIFT = 5'b00100,
    SPC_TRAIL = 5'b01000,
    SPC_GAP   = 5'b10000
  } spc_state_t;
endpackage : spc_pkg

// *** hw/spc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module spc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  output logic              full,
  output logic              empty
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic          do_wr, do_rd;
  // ----------------------------------------------------------------
  // pointers and fill count
  // ----------------------------------------------------------------
  always_comb begin
    full      = (cnt == (AW+1)'(D));
    empty     = (cnt == '0);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = mem[rp];
    do_wr     = in_valid && in_ready;
    do_rd     = out_valid && out_ready;
    next_wp   = do_wr ? wp + 1'b1 : wp;
    next_rp   = do_rd ? rp + 1'b1 : rp;
    next_cnt  = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (flush) begin
      next_wp  = '0;
      next_rp  = '0;
      next_cnt = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
    if (do_wr) mem[wp] <= in_data;
  end
endmodule : spc_fifo
`default_nettype wire

// *** dv/spc_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module spc_port_properties
  import spc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [1:0]  wb_sel_i,
  input wire logic [15:0] wb_dat_i,
  input wire logic [15:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sck_o,
  input wire logic        sel_n_o,
  input wire logic        sel_n_oe,
  input wire logic        mosi_o,
  input wire logic        mosi_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // bus request steps
  // ---------------------------------------------------------------
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s(a);
    take_s ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  sequence sel_off_s;
    take_s ##0 (wb_we_i && wb_adr_i == SPC_ADR_CFG && wb_sel_i[0] && !wb_dat_i[5]);
  endsequence
  AST_ACK_ONE: assert property (take_s |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RST_IDLE: assert property (disable iff (1'b0) rst |=>
    (sck_o && sel_n_o && !sel_n_oe && !mosi_oe && !wb_ack_o))
    else $error("outputs not idle after reset");
  AST_CFG_RSVD: assert property (rd_s(SPC_ADR_CFG) |=> !wb_dat_o[8])
    else $error("reserved config bit reads one");
  AST_ICLR_ZERO: assert property (rd_s(SPC_ADR_ICLR) |=> wb_dat_o == 16'h0000)
    else $error("write-only register read nonzero");
  AST_STAT_ZERO: assert property (rd_s(SPC_ADR_STAT) |=> wb_dat_o == 16'h0000)
    else $error("status read nonzero");
  AST_UNMAPPED: assert property (take_s ##0 (!wb_we_i &&
    (wb_adr_i < 16'hc0c8 || wb_adr_i > 16'hc0de)) |=> wb_dat_o == 16'h0000)
    else $error("unmapped read nonzero");
  AST_SEL_OFF: assert property (sel_off_s |-> ##[1:2] !sel_n_oe)
    else $error("select still driven after disable");
endmodule : spc_port_properties
bind spc_port spc_port_properties u_props (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_o(sck_o), .sel_n_o(sel_n_o),
  .sel_n_oe(sel_n_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe));
`default_nettype wire

// *** dv/spc_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module spc_peer #(
  parameter logic [7:0] TX = 8'h3c
) (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       adv,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh;
  wire        lvl;
  initial begin
    miso = 1'b0;
    rx   = 8'h00;
    sh   = TX;
  end
  // clock level relative to idle: rises on the leading edge in either polarity
  assign lvl = sck ^ !pol;
  // deselected: line shows the inverse, shifter reloads; selected: next bit out
  // on the leading edge (delayed phase) or at select fall and trailing edges (advanced)
  always @(lvl or sel_n) begin
    if (sel_n) begin
      miso <= ~miso;
      sh   <= TX;
    end else if (lvl != adv) begin
      miso <= sh[7];
      sh   <= {sh[6:0], 1'b0};
    end
  end
  // bit in on the trailing edge (delayed phase) or the leading edge (advanced)
  always @(lvl) begin
    if (!sel_n && (lvl == adv)) rx <= {rx[6:0], mosi};
  end
endmodule : spc_peer
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import spc_pkg::*;
;
  logic        clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000, wdat = 16'h0000, rdat, q;
  logic [1:0]  sel = 2'b00;
  logic        ack, sck, sel_n, sel_oe, mosi, mosi_oe, miso;
  logic        ppol = 1'b0, padv = 1'b0;
  logic [7:0]  peer_rx;
  wire         sel_line;
  int          failures = 0, compares = 0, n;
  int          khz [16] = '{12000, 8000, 6000, 4000, 3000, 2000, 1500, 1000,
                            750, 500, 375, 250, 375, 250, 375, 250};
  assign sel_line = sel_oe ? sel_n : 1'b1;
  always #5 clk_sys = ~clk_sys;
  spc_port dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sck_o(sck), .sel_n_o(sel_n), .sel_n_oe(sel_oe), .mosi_o(mosi),
    .mosi_oe(mosi_oe), .miso_i(miso), .sdio_i(miso));
  spc_peer #(.TX(8'h3c)) peer (.sck(sck), .sel_n(sel_line), .mosi(mosi), .pol(ppol),
    .adv(padv), .miso(miso), .rx(peer_rx));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task oops(input string m);
    failures++;
    $display("Error %0t: %s", $time, m);
    give_verdict();
  endtask : oops
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [1:0] s);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) oops("bus timeout");
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task wait_sel(input logic v, input int lim);
    int k;
    k = 0;
    while (sel_line !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= lim) oops("select timeout");
  endtask : wait_sel
  task wait_chg(output int k);
    logic s0;
    s0 = sck;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (sck === s0 && k < 1000);
    if (k >= 1000) oops("clock timeout");
  endtask : wait_chg
  task wait_idle();
    int k;
    k = 0;
    do begin
      bus(1'b0, SPC_ADR_CFG, 16'h0000, 2'b11);
      k++;
    end while (q[7] !== 1'b0 && k < 200);
    if (k >= 200) oops("machine stays active");
  endtask : wait_idle
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_map();
    bus(1'b0, SPC_ADR_CFG, 16'h0000, 2'b11); chk(q, 16'h801f, "cfg reset");
    bus(1'b1, SPC_ADR_STAT, 16'hffff, 2'b11);
    bus(1'b0, SPC_ADR_STAT, 16'h0000, 2'b11); chk(q, 16'h0000, "status");
    bus(1'b0, SPC_ADR_ICLR, 16'h0000, 2'b11); chk(q, 16'h0000, "clear read");
    bus(1'b0, 16'hc0e0, 16'h0000, 2'b11); chk(q, 16'h0000, "unmapped");
    for (int a = 16'hc0d2; a <= 16'hc0de; a += 2) begin
      if (a == 16'hc0d6) continue;
      bus(1'b1, a[15:0], 16'h5a00 | a[15:0], 2'b11);
      bus(1'b0, a[15:0], 16'h0000, 2'b11); chk(q, 16'h5a00 | a[15:0], "storage");
    end
    $display("t_map done");
  endtask : t_map
  task t_cfg();
    bus(1'b1, SPC_ADR_CFG, 16'hffff, 2'b11);
    bus(1'b0, SPC_ADR_CFG, 16'h0000, 2'b11); chk(q, 16'hfe7f, "cfg all ones");
    bus(1'b1, SPC_ADR_CFG, 16'h8000, 2'b11);
    bus(1'b1, SPC_ADR_CTL, 16'h1000, 2'b11);
    bus(1'b0, SPC_ADR_CTL, 16'h0000, 2'b11); chk(q & 16'h1000, 16'h0000, "dup");
    bus(1'b1, SPC_ADR_CFG, 16'h0000, 2'b11);
    bus(1'b1, SPC_ADR_CTL, 16'h1000, 2'b11);
    bus(1'b0, SPC_ADR_CTL, 16'h0000, 2'b11); chk(q & 16'h1000, 16'h1000, "dup");
    $display("t_cfg done");
  endtask : t_cfg
  task t_manual();
    bus(1'b1, SPC_ADR_CFG, 16'h0060, 2'b11);
    bus(1'b1, SPC_ADR_CTL, 16'h0800, 2'b11);
    chk({14'h0, sel_oe, sel_n}, 16'h0002, "forced low");
    bus(1'b1, SPC_ADR_CTL, 16'h0000, 2'b11);
    chk({14'h0, sel_oe, sel_n}, 16'h0003, "forced high");
    bus(1'b1, SPC_ADR_CFG, 16'h0040, 2'b11);
    chk({15'h0, sel_oe}, 16'h0000, "select released");
    $display("t_manual done");
  endtask : t_manual
  task t_fifo();
    bus(1'b1, SPC_ADR_CFG, 16'h0000, 2'b11);
    for (int i = 0; i < 15; i++) bus(1'b1, SPC_ADR_DATA, 16'h0011, 2'b01);
    bus(1'b0, SPC_ADR_CTL, 16'h0000, 2'b11); chk(q & 16'h0280, 16'h0200, "room");
    repeat (2) bus(1'b1, SPC_ADR_DATA, 16'h0022, 2'b01);
    bus(1'b0, SPC_ADR_CTL, 16'h0000, 2'b11); chk(q & 16'h0280, 16'h0000, "full");
    bus(1'b1, SPC_ADR_CTL, 16'h4000, 2'b10);
    bus(1'b0, SPC_ADR_CTL, 16'h0000, 2'b11); chk(q & 16'h0280, 16'h0280, "empty");
    $display("t_fifo done");
  endtask : t_fifo
  task t_auto();
    bus(1'b1, SPC_ADR_CFG, 16'h0062, 2'b11);
    bus(1'b1, SPC_ADR_DATA, 16'h00a5, 2'b01);
    wait_sel(1'b0, 100);
    wait_chg(n); chk(n[15:0], 16'd8, "lead delay");
    wait_chg(n); chk(n[15:0], 16'd4, "half bit");
    bus(1'b1, SPC_ADR_CFG, 16'h0022, 2'b11);
    bus(1'b0, SPC_ADR_CFG, 16'h0000, 2'b11); chk(q & 16'h00c0, 16'h00c0, "busy");
    wait_sel(1'b1, 200);
    chk({8'h00, peer_rx}, 16'h00a5, "sent byte");
    wait_idle();
    bus(1'b0, SPC_ADR_DATA, 16'h0000, 2'b11); chk(q & 16'h00ff, 16'h003c, "rx");
    bus(1'b1, SPC_ADR_CFG, 16'h0022, 2'b11);
    bus(1'b0, SPC_ADR_CFG, 16'h0000, 2'b11); chk(q & 16'h0040, 16'h0000, "role");
    $display("t_auto done");
  endtask : t_auto
  task t_scale();
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, SPC_ADR_CFG, 16'h0061 | 16'(c << 9), 2'b11);
      bus(1'b1, SPC_ADR_DATA, 16'h0081, 2'b01);
      wait_sel(1'b0, 100);
      wait_chg(n);
      wait_chg(n); chk(n[15:0], 16'(50000 / khz[c]), "scale");
      wait_sel(1'b1, 5000);
      wait_idle();
    end
    $display("t_scale done");
  endtask : t_scale
  task t_modes();
    bus(1'b1, SPC_ADR_CFG, 16'h6060, 2'b11);
    ppol <= 1'b1;
    padv <= 1'b1;
    bus(1'b1, SPC_ADR_CTL, 16'h0800, 2'b11);
    chk({15'h0, sck}, 16'h0000, "positive idle");
    bus(1'b1, SPC_ADR_DATA, 16'h005a, 2'b01);
    wait_idle();
    chk({8'h00, peer_rx}, 16'h005a, "advanced sent");
    bus(1'b0, SPC_ADR_DATA, 16'h0000, 2'b11); chk(q & 16'h00ff, 16'h003c, "advanced rx");
    bus(1'b1, SPC_ADR_CTL, 16'h0000, 2'b11);
    $display("t_modes done");
  endtask : t_modes
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_map();
    t_cfg();
    t_manual();
    t_fifo();
    t_auto();
    t_scale();
    t_modes();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
